/* scwt_params.svh */
`ifndef SCWT_PARAMS_SVH
`define SCWT_PARAMS_SVH
// Operation
// RULE1: Input direction: read returns live data pin
// RULE2: Output direction: written bit drives data pin
// RULE3: Pin bits act only in bypass/sync modes
// RULE4: Sync mode: bit holds level at clock rise
// RULE5: Direction bit one is input, zero output
// RULE6: Stop bit halts clock at chosen level
// RULE7: Bypass: level bit drives clock, stop ignored
// RULE8: Firmware sequences clock stop and restart itself
// RULE9: Firmware uses user pins for auxiliary contacts
// RULE10: ETU divider from rate and adjust codes
// RULE11: Block limit is 28 bits over four bytes
// RULE12: Block mode: last sent start to reply
// RULE13: Character mode: gap between any consecutive characters
// RULE14: Either timer passing limit raises interrupt
// RULE15: Firmware loads block limit before last byte
// RULE16: Character limit 16 bits, low byte higher address
// RULE17: Character timer spans consecutive received start edges
// RULE18: Firmware loads wait values before reception begins
// RULE19: Sync mode: sample on rise, change on fall
// RULE20: Bypass: firmware handles framing, parity, answer-to-reset
// RULE21: Timer restarts at zero, stops at limit

//==================================================================
// Register map
`define SCWT_ADDR_W      16
`define SCWT_OFF_PIN_CTL 16'hfe0b
`define SCWT_OFF_BW3     16'hfe18
`define SCWT_OFF_BW2     16'hfe19
`define SCWT_OFF_BW1     16'hfe1a
`define SCWT_OFF_BW0     16'hfe1b
`define SCWT_OFF_CW1     16'hfe1c
`define SCWT_OFF_CW0     16'hfe1d

//==================================================================
// Field positions of the pin control register
`define SCWT_BIT_DATA    5
`define SCWT_BIT_DIR     4
`define SCWT_BIT_LVL     1
`define SCWT_BIT_STOP    0

//==================================================================
// Reset values and widths
`define SCWT_RST_BYTE    8'h00
`define SCWT_BW_W        28
`define SCWT_CW_W        16
`define SCWT_DIV_W       13
`define SCWT_BW3_BITS    4

`endif

/* scwt_pkg.sv */
package scwt_pkg;

   //===============================================================
   // Stored pin control bits
   typedef struct packed {
      logic data;       // Written data pin value
      logic dir;        // One is input, zero output
      logic clk_level;  // Clock level when stopped or bypassed
      logic clk_stop;   // Clock stop request
   } scwt_pin_ctl_t;

   //===============================================================
   // Interface operating mode, one-hot
   typedef enum logic [2:0] {
      SCWT_MODE_ASYNC  = 3'b001,
      SCWT_MODE_BYPASS = 3'b010,
      SCWT_MODE_SYNC   = 3'b100
   } scwt_mode_t;

   //===============================================================
   // Character start events from the UART
   typedef struct packed {
      logic tx_start;   // Leading edge of a sent character
      logic rx_start;   // Start bit of a received character
   } scwt_char_evt_t;

endpackage

/* scwt_wait_timer.sv */
`timescale 1ns/100ps
module scwt_wait_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         nrst_i,
   // Control
   input  wire logic         restart_i,
   input  wire logic         halt_i,
   input  wire logic         etu_tick_i,
   input  wire logic [W-1:0] limit_i,
   // Status
   output logic              running_o,
   output logic              timeout_o
);

   //===============================================================
   // Counter state
   logic [W-1:0] count_q;     // ETUs elapsed since the start edge
   logic         run_q;       // Counting
   logic         tmo_q;       // One-cycle timeout pulse
   wire          at_limit  = (count_q == limit_i);
   wire          step      = run_q & etu_tick_i;
   wire          expire    = step & at_limit & ~restart_i & ~halt_i;

   // Restart beats halt so a new start edge is never lost
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         count_q <= '0;
         run_q   <= 1'b0;
         tmo_q   <= 1'b0;
      end
      else
      begin
         tmo_q <= expire;                     // see RULE14
         if (restart_i)
         begin
            count_q <= '0;                    // see RULE21
            run_q   <= 1'b1;
         end
         else if (halt_i || expire)
            run_q <= 1'b0;                    // see RULE21
         else if (step)
            count_q <= count_q + 1'b1;
      end
   end

   assign running_o = run_q;
   assign timeout_o = tmo_q;

   //===============================================================
   // Checks
   restart_zero_a: assert property (@(posedge ref_clk_i) // see RULE21
      disable iff (!nrst_i) restart_i |=> (count_q == '0) && run_q)
      else $error("timer did not restart from zero");

   timeout_cause_a: assert property (@(posedge ref_clk_i) // see RULE14
      disable iff (!nrst_i)
      timeout_o |-> $past(at_limit) && $past(step) && !run_q)
      else $error("timeout without count reaching limit");

endmodule

/* scwt_card_port.sv */
`timescale 1ns/100ps
`include "scwt_params.svh"
module scwt_card_port (
   // Clock and reset
   input  wire logic                    ref_clk_i,
   input  wire logic                    nrst_i,
   // Processor register port
   input  wire logic [`SCWT_ADDR_W-1:0] reg_addr_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   input  wire logic [7:0]              reg_wdata_i,
   output logic      [7:0]              reg_rdata_o,
   // Mode and rate selection
   input  wire scwt_pkg::scwt_mode_t    mode_i,
   input  wire logic                    block_proto_i,
   input  wire logic [3:0]              clock_rate_code_i,
   input  wire logic [3:0]              baud_adjust_code_i,
   // Card clock source
   input  wire logic                    card_clk_tick_i,
   input  wire logic                    card_clk_level_i,
   // Character events
   input  wire scwt_pkg::scwt_char_evt_t char_evt_i,
   // External card pins
   input  wire logic                    ext_card_data_pin_i,
   output logic                         ext_card_data_pin_o,
   output logic                         ext_card_data_pin_oe_o,
   output logic                         ext_card_clk_o,
   // Timeout interrupts
   output logic                         block_wait_timeout_o,
   output logic                         char_wait_timeout_o
);

   //===============================================================
   // Registers
   scwt_pkg::scwt_pin_ctl_t     ctl_q;  // Pin control bits
   logic [`SCWT_BW_W-1:0]       bw_q;   // Block or work wait limit
   logic [`SCWT_CW_W-1:0]       cw_q;   // Character or initial limit
   logic [7:0]                  rdata_q;
   logic                        pin_s1_q;
   logic                        pin_s2_q;
   logic                        cap_q;  // Level at last sync rise
   logic                        dout_q;
   logic                        oe_q;
   logic                        clk_q;
   logic                        sync_clk_q;
   logic [`SCWT_DIV_W-1:0]      etu_cnt_q;

   //===============================================================
   // Mode decode
   wire is_bypass = (mode_i == scwt_pkg::SCWT_MODE_BYPASS);
   wire is_sync   = (mode_i == scwt_pkg::SCWT_MODE_SYNC);
   wire pin_mode  = is_bypass | is_sync;

   //===============================================================
   // ETU divider lookup, rounded to nearest; one entry deviates
   function automatic logic [`SCWT_DIV_W-1:0] etu_div(
      input logic [3:0] fi,
      input logic [3:0] di
   );
      logic [`SCWT_DIV_W-1:0] two_f;
      logic [`SCWT_DIV_W-1:0] d;
      two_f = 13'd744;
      d     = 13'd1;
      unique case (fi)
         4'h2:    two_f = 13'd1116;
         4'h3:    two_f = 13'd1488;
         4'h4:    two_f = 13'd2232;
         4'h5:    two_f = 13'd2976;
         4'h6:    two_f = 13'd3720;
         4'h9:    two_f = 13'd1024;
         4'ha:    two_f = 13'd1536;
         4'hb:    two_f = 13'd2048;
         4'hc:    two_f = 13'd3072;
         4'hd:    two_f = 13'd4096;
         default: two_f = 13'd744;   // Codes 0, 1 and reserved
      endcase
      unique case (di)
         4'h2:    d = 13'd2;
         4'h3:    d = 13'd4;
         4'h4:    d = 13'd8;
         4'h8:    d = 13'd12;
         4'h5:    d = 13'd16;
         4'h9:    d = 13'd20;
         4'h6:    d = 13'd32;
         default: d = 13'd1;         // Code 1 and reserved
      endcase
      // Hardware table keeps 138 where rounding would give 140
      if (fi == 4'h2 && di == 4'h4)
         etu_div = 13'd138;
      else
         etu_div = (two_f + (d >> 1)) / d;
   endfunction

   wire [`SCWT_DIV_W-1:0] div      = etu_div(clock_rate_code_i,
                                             baud_adjust_code_i); // see RULE10
   wire [`SCWT_DIV_W-1:0] half     = div >> 1;
   wire                   etu_tick = card_clk_tick_i &
                                     (etu_cnt_q == div - 1'b1);
   wire                   sync_fall = card_clk_tick_i &
                                     (etu_cnt_q == half - 1'b1);

   // ETU counter, also the sync mode clock source
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         etu_cnt_q <= '0;
      else if (etu_tick)
         etu_cnt_q <= '0;                    // see RULE10
      else if (card_clk_tick_i)
         etu_cnt_q <= etu_cnt_q + 1'b1;
   end

   // Sync clock rises at each ETU boundary, falls at half period
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sync_clk_q <= 1'b0;
      else if (etu_tick)
         sync_clk_q <= 1'b1;
      else if (sync_fall)
         sync_clk_q <= 1'b0;
   end

   //===============================================================
   // Pin input synchroniser; read-back lags the pin by two cycles
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end
      else
      begin
         pin_s1_q <= ext_card_data_pin_i;
         pin_s2_q <= pin_s1_q;
      end
   end

   // Capture data on the sync clock rise
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cap_q <= 1'b0;
      else if (is_sync && etu_tick)
         cap_q <= pin_s2_q;                  // see RULE4 RULE19
   end

   //===============================================================
   // Register write decode
   wire wr_ctl = reg_wr_i & (reg_addr_i == `SCWT_OFF_PIN_CTL);
   wire wr_bw3 = reg_wr_i & (reg_addr_i == `SCWT_OFF_BW3);
   wire wr_bw2 = reg_wr_i & (reg_addr_i == `SCWT_OFF_BW2);
   wire wr_bw1 = reg_wr_i & (reg_addr_i == `SCWT_OFF_BW1);
   wire wr_bw0 = reg_wr_i & (reg_addr_i == `SCWT_OFF_BW0);
   wire wr_cw1 = reg_wr_i & (reg_addr_i == `SCWT_OFF_CW1);
   wire wr_cw0 = reg_wr_i & (reg_addr_i == `SCWT_OFF_CW0);

   // Pin control register; unused bits are not stored
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ctl_q <= '0;
      else if (wr_ctl)
      begin
         ctl_q.data      <= reg_wdata_i[`SCWT_BIT_DATA];
         ctl_q.dir       <= reg_wdata_i[`SCWT_BIT_DIR];
         ctl_q.clk_level <= reg_wdata_i[`SCWT_BIT_LVL];
         ctl_q.clk_stop  <= reg_wdata_i[`SCWT_BIT_STOP];
      end
   end

   // Wait limits, one byte per write
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         bw_q <= '0;
         cw_q <= '0;
      end
      else
      begin
         if (wr_bw0) bw_q[7:0]   <= reg_wdata_i;           // see RULE11
         if (wr_bw1) bw_q[15:8]  <= reg_wdata_i;
         if (wr_bw2) bw_q[23:16] <= reg_wdata_i;
         if (wr_bw3) bw_q[27:24] <= reg_wdata_i[3:0];      // see RULE11
         if (wr_cw0) cw_q[7:0]   <= reg_wdata_i;           // see RULE16
         if (wr_cw1) cw_q[15:8]  <= reg_wdata_i;           // see RULE16
      end
   end

   //===============================================================
   // Register read mux; pin bit shows the pin when it is an input
   wire       pin_seen = is_sync ? cap_q : pin_s2_q;
   wire       rd_data  = ctl_q.dir ? pin_seen : ctl_q.data; // see RULE1
   wire [7:0] rd_ctl   = {2'b00, rd_data, ctl_q.dir, 2'b00,
                          ctl_q.clk_level, ctl_q.clk_stop};
   wire [7:0] rd_mux   =
      (reg_addr_i == `SCWT_OFF_PIN_CTL) ? rd_ctl :
      (reg_addr_i == `SCWT_OFF_BW3) ? {4'h0, bw_q[27:24]} :
      (reg_addr_i == `SCWT_OFF_BW2) ? bw_q[23:16] :
      (reg_addr_i == `SCWT_OFF_BW1) ? bw_q[15:8] :
      (reg_addr_i == `SCWT_OFF_BW0) ? bw_q[7:0] :
      (reg_addr_i == `SCWT_OFF_CW1) ? cw_q[15:8] :
      (reg_addr_i == `SCWT_OFF_CW0) ? cw_q[7:0] : `SCWT_RST_BYTE;

   // Read data is registered and cleared between reads
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_q <= `SCWT_RST_BYTE;
      else
         rdata_q <= reg_rd_i ? rd_mux : `SCWT_RST_BYTE;
   end

   //===============================================================
   // Pin drivers; outside bypass and sync the UART owns the data pin, the stop bit still acts on the clock
   wire dout_d = is_sync ? (sync_fall ? ctl_q.data : dout_q)
                         : ctl_q.data;       // see RULE2 RULE19
   wire oe_d   = pin_mode & ~ctl_q.dir;      // see RULE3 RULE5
   wire clk_d  = (is_bypass | ctl_q.clk_stop) ? ctl_q.clk_level :
                 is_sync ? sync_clk_q : card_clk_level_i; // see RULE6 RULE7

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         dout_q <= 1'b0;
         oe_q   <= 1'b0;
         clk_q  <= 1'b0;
      end
      else
      begin
         dout_q <= dout_d;
         oe_q   <= oe_d;
         clk_q  <= clk_d;
      end
   end

   assign ext_card_data_pin_o    = dout_q;
   assign ext_card_data_pin_oe_o = oe_q;
   assign ext_card_clk_o         = clk_q;
   assign reg_rdata_o            = rdata_q;

   //===============================================================
   // Wait timers; block mode halts at the reply, character mode
   // restarts on every character in either direction
   wire bw_restart = block_proto_i ? char_evt_i.tx_start      // see RULE12
                   : (char_evt_i.tx_start | char_evt_i.rx_start); // see RULE13
   wire bw_halt    = block_proto_i & char_evt_i.rx_start;      // see RULE12

   scwt_wait_timer #(
      .W (`SCWT_BW_W)
   ) u_block_wait (
      .ref_clk_i  (ref_clk_i),
      .nrst_i     (nrst_i),
      .restart_i  (bw_restart),
      .halt_i     (bw_halt),
      .etu_tick_i (etu_tick),
      .limit_i    (bw_q),
      .running_o  (),
      .timeout_o  (block_wait_timeout_o)                        // see RULE14
   );

   // Character timer spans received start edges; sending ends it
   scwt_wait_timer #(
      .W (`SCWT_CW_W)
   ) u_char_wait (
      .ref_clk_i  (ref_clk_i),
      .nrst_i     (nrst_i),
      .restart_i  (char_evt_i.rx_start),                        // see RULE17
      .halt_i     (char_evt_i.tx_start),
      .etu_tick_i (etu_tick),
      .limit_i    (cw_q),
      .running_o  (),
      .timeout_o  (char_wait_timeout_o)                         // see RULE14
   );

   //===============================================================
   // Checks
   bypass_clk_a: assert property (@(posedge ref_clk_i) // see RULE7
      disable iff (!nrst_i)
      is_bypass |=> ext_card_clk_o == $past(ctl_q.clk_level))
      else $error("bypass clock not following level bit");

   stop_level_a: assert property (@(posedge ref_clk_i) // see RULE6
      disable iff (!nrst_i) ctl_q.clk_stop [*2] |=>
      ext_card_clk_o == $past(ctl_q.clk_level))
      else $error("stopped clock not at idle level");

   dir_input_a: assert property (@(posedge ref_clk_i) // see RULE5
      disable iff (!nrst_i) ctl_q.dir |=> !ext_card_data_pin_oe_o)
      else $error("data pin driven while set as input");

   idle_mode_a: assert property (@(posedge ref_clk_i) // see RULE3
      disable iff (!nrst_i) !pin_mode |=> !ext_card_data_pin_oe_o)
      else $error("data pin driven outside bypass and sync");

   bypass_drive_a: assert property (@(posedge ref_clk_i) // see RULE2
      disable iff (!nrst_i) (is_bypass && !ctl_q.dir) |=>
      ext_card_data_pin_oe_o &&
      ext_card_data_pin_o == $past(ctl_q.data))
      else $error("bypass output not driving written bit");

   sync_capture_a: assert property (@(posedge ref_clk_i) // see RULE4
      disable iff (!nrst_i) (is_sync && etu_tick) |=>
      cap_q == $past(pin_s2_q) ##1 $stable(cap_q) || $past(etu_tick))
      else $error("sync capture missed clock rise");

   read_pin_a: assert property (@(posedge ref_clk_i) // see RULE1
      disable iff (!nrst_i) (reg_rd_i && ctl_q.dir && !is_sync &&
      reg_addr_i == `SCWT_OFF_PIN_CTL) |=>
      reg_rdata_o[`SCWT_BIT_DATA] == $past(pin_s2_q))
      else $error("read of input pin returned wrong level");

   etu_wrap_a: assert property (@(posedge ref_clk_i) // see RULE10
      disable iff (!nrst_i) etu_tick |=> etu_cnt_q == '0)
      else $error("ETU counter did not wrap at divider");

   sync_change_a: assert property (@(posedge ref_clk_i) // see RULE19
      disable iff (!nrst_i) (is_sync && !sync_fall) ##1 is_sync |->
      $stable(ext_card_data_pin_o) || $past(sync_fall, 2) ||
      $past(is_sync, 2) == 1'b0)
      else $error("sync data changed away from clock fall");

endmodule

/* scwt_card_model.sv */
`timescale 1ns/100ps
module scwt_card_model (
   // Reader side of the data line
   input  wire logic host_oe_i,
   input  wire logic host_val_i,
   // Card transmitter, steered by the bench
   input  wire logic send_en_i,
   input  wire logic send_bit_i,
   // Resolved line level
   output logic      line_o
);
   //===============================================================
   // Line resolution
   // The card line has a pull-up, so a released line reads high.
   // Both ends driving at once is a clash and shows as unknown.
   // Auxiliary contacts are not modelled: they sit on user pins
   // outside this port
   assign line_o = (host_oe_i && send_en_i) ? 1'bx :
                   host_oe_i ? host_val_i :
                   send_en_i ? send_bit_i : 1'b1;
endmodule

/* test_smart_card_wait_timing.sv */
`timescale 1ns/100ps
`include "scwt_params.svh"
module test_smart_card_wait_timing;
   //===============================================================
   // Bench signals
   logic                     ref_clk_i;     // 50 MHz clock
   logic                     nrst_i;        // Reset, active low
   logic [`SCWT_ADDR_W-1:0]  reg_addr_i;    // Register address
   logic                     reg_wr_i;      // Write strobe
   logic                     reg_rd_i;      // Read strobe
   logic [7:0]               reg_wdata_i;   // Write data
   logic [7:0]               reg_rdata_o;   // Read data
   scwt_pkg::scwt_mode_t     mode_i;        // Port mode
   logic                     block_proto_i; // Block protocol select
   logic [3:0]               rate_code;     // Clock rate code
   logic [3:0]               adj_code;      // Baud adjust code
   logic                     card_clk_tick_i;
   logic                     card_clk_level_i;
   scwt_pkg::scwt_char_evt_t char_evt_i;    // Character start pulses
   logic                     line;          // Resolved data line
   logic                     data_o;        // Reader data value
   logic                     data_oe;       // Reader drives line
   logic                     clk_o;         // Card clock pin
   logic                     bw_to;         // Block wait timeout
   logic                     cw_to;         // Char wait timeout
   logic                     send_en;       // Card drives line
   logic                     send_bit;      // Card data value
   int                       fails;         // Mismatch count
   int                       cmp_count;     // Comparison count
   // Every mapped place plus one unmapped neighbour
   localparam logic [15:0] reg_map [8] = '{`SCWT_OFF_PIN_CTL,
      `SCWT_OFF_BW3, `SCWT_OFF_BW2, `SCWT_OFF_BW1, `SCWT_OFF_BW0,
      `SCWT_OFF_CW1, `SCWT_OFF_CW0, 16'hfe0c};

   //===============================================================
   // Design and card
   scwt_card_port i_dut (
      .ref_clk_i              (ref_clk_i),
      .nrst_i                 (nrst_i),
      .reg_addr_i             (reg_addr_i),
      .reg_wr_i               (reg_wr_i),
      .reg_rd_i               (reg_rd_i),
      .reg_wdata_i            (reg_wdata_i),
      .reg_rdata_o            (reg_rdata_o),
      .mode_i                 (mode_i),
      .block_proto_i          (block_proto_i),
      .clock_rate_code_i      (rate_code),
      .baud_adjust_code_i     (adj_code),
      .card_clk_tick_i        (card_clk_tick_i),
      .card_clk_level_i       (card_clk_level_i),
      .char_evt_i             (char_evt_i),
      .ext_card_data_pin_i    (line),
      .ext_card_data_pin_o    (data_o),
      .ext_card_data_pin_oe_o (data_oe),
      .ext_card_clk_o         (clk_o),
      .block_wait_timeout_o   (bw_to),
      .char_wait_timeout_o    (cw_to)
   );
   scwt_card_model i_card (
      .host_oe_i  (data_oe),
      .host_val_i (data_o),
      .send_en_i  (send_en),
      .send_bit_i (send_bit),
      .line_o     (line)
   );

   //===============================================================
   // Clocks
   initial
   begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   // Card clock source ticks every other cycle, so one ETU is 2*div
   always @(posedge ref_clk_i)
      card_clk_tick_i <= #1 ~card_clk_tick_i;

   //===============================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      cycles(1);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      cycles(1);
      reg_wr_i = 1'b0;
   endtask
   // Read data stands for the one cycle after the taking edge
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      cycles(1);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      cycles(1);
      reg_rd_i = 1'b0;
      chk({24'h00_0000, reg_rdata_o}, {24'h00_0000, e});
   endtask
   task automatic evt(input logic tx, input logic rx);
      cycles(1);
      char_evt_i.tx_start = tx;
      char_evt_i.rx_start = rx;
      cycles(1);
      char_evt_i = '0;
   endtask
   // Waits up to hi cycles for a timeout pulse; a hit must not be early
   task automatic wait_out(input bit blk, input int lo, input int hi,
                           input bit exp_hit);
      int   n;
      logic hit;
      n = 0;
      hit = 1'b0;
      while (n < hi && hit !== 1'b1)
      begin
         cycles(1);
         n++;
         hit = blk ? bw_to : cw_to;
      end
      chk({31'h0, (hit === 1'b1) && (n >= lo)}, {31'h0, exp_hit});
   endtask
   task automatic wait_rise;
      int   n;
      logic prev;
      n = 0;
      prev = clk_o;
      while (n < 4000 && !(prev === 1'b0 && clk_o === 1'b1))
      begin
         prev = clk_o;
         cycles(1);
         n++;
      end
   endtask
   // Sync clock period in reference cycles
   task automatic period(input int e);
      realtime t0;
      wait_rise();
      t0 = $realtime;
      wait_rise();
      chk(32'(int'(($realtime - t0) / 20.0)), e);
   endtask
   task automatic done(input string s);
      $display("Test %s finished, mismatches so far %0d", s, fails);
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   //===============================================================
   // Watchdog, well beyond the expected run of some 6000 cycles
   initial
   begin
      repeat (60000) @(posedge ref_clk_i);
      fails++;
      wrap_up();
   end

   //===============================================================
   // Test sequence
   initial
   begin
      fails = 0;
      cmp_count = 0;
      nrst_i = 1'b0;
      reg_addr_i = '0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_wdata_i = 8'h00;
      mode_i = scwt_pkg::SCWT_MODE_ASYNC;
      block_proto_i = 1'b1;
      rate_code = 4'h0;
      adj_code = 4'h6;            // Divider 23, one ETU of 46 cycles
      card_clk_tick_i = 1'b0;
      card_clk_level_i = 1'b0;
      char_evt_i = '0;
      send_en = 1'b0;
      send_bit = 1'b1;
      cycles(10);
      nrst_i = 1'b1;
      // Reset values, widths and the unmapped place
      wr(16'hfe0c, 8'hff);
      for (int i = 0; i < 8; i++)
         rd(reg_map[i], 8'h00);
      wr(`SCWT_OFF_BW3, 8'hff);
      rd(`SCWT_OFF_BW3, 8'h0f);
      for (int i = 2; i < 7; i++)
      begin
         wr(reg_map[i], 8'h5a ^ 8'(i));
         rd(reg_map[i], 8'h5a ^ 8'(i));
      end
      done("registers");
      // Async mode: only the stop bit acts, released line reads high
      wr(`SCWT_OFF_PIN_CTL, 8'hff);
      rd(`SCWT_OFF_PIN_CTL, 8'h33);
      chk(clk_o, 1'b1);
      wr(`SCWT_OFF_PIN_CTL, 8'h20);
      card_clk_level_i = 1'b1;
      cycles(2);
      chk(data_oe, 1'b0);
      chk(clk_o, 1'b1);
      card_clk_level_i = 1'b0;
      cycles(2);
      chk(clk_o, 1'b0);
      done("async pins");
      // Bypass: firmware drives and reads the line itself
      mode_i = scwt_pkg::SCWT_MODE_BYPASS;
      wr(`SCWT_OFF_PIN_CTL, 8'h23);
      cycles(2);
      chk({data_oe, data_o, clk_o}, 3'b111);
      wr(`SCWT_OFF_PIN_CTL, 8'h00);
      cycles(2);
      chk({data_oe, data_o, clk_o}, 3'b100);
      wr(`SCWT_OFF_PIN_CTL, 8'h10);
      send_en = 1'b1;
      send_bit = 1'b0;
      cycles(3);
      chk(data_oe, 1'b0);
      rd(`SCWT_OFF_PIN_CTL, 8'h10);
      send_bit = 1'b1;
      cycles(3);
      rd(`SCWT_OFF_PIN_CTL, 8'h30);
      send_en = 1'b0;
      done("bypass");
      // Character timer, limit 3 ETUs, loaded before reception
      mode_i = scwt_pkg::SCWT_MODE_ASYNC;
      wr(`SCWT_OFF_CW1, 8'h00);
      wr(`SCWT_OFF_CW0, 8'h03);
      evt(1'b0, 1'b1);
      wait_out(1'b0, 136, 190, 1'b1);
      evt(1'b0, 1'b1);
      cycles(100);
      evt(1'b0, 1'b1);
      wait_out(1'b0, 136, 190, 1'b1);
      done("char timer");
      // Block timer, limit 2 ETUs, loaded before the last sent byte
      for (int i = 1; i < 4; i++)
         wr(reg_map[i], 8'h00);
      wr(`SCWT_OFF_BW0, 8'h02);
      evt(1'b1, 1'b0);
      wait_out(1'b1, 90, 144, 1'b1);
      evt(1'b1, 1'b0);
      cycles(40);
      evt(1'b0, 1'b1);
      wait_out(1'b1, 0, 300, 1'b0);
      block_proto_i = 1'b0;
      evt(1'b1, 1'b0);
      cycles(60);
      evt(1'b0, 1'b1);
      wait_out(1'b1, 90, 144, 1'b1);
      done("block timer");
      // Sync mode: capture at clock rise, stop and restart the clock
      mode_i = scwt_pkg::SCWT_MODE_SYNC;
      wr(`SCWT_OFF_PIN_CTL, 8'h10);
      send_en = 1'b1;
      send_bit = 1'b0;
      // Let the new level clear the synchroniser before the next rise
      cycles(3);
      wait_rise();
      cycles(2);
      rd(`SCWT_OFF_PIN_CTL, 8'h10);
      send_bit = 1'b1;
      wait_rise();
      cycles(2);
      rd(`SCWT_OFF_PIN_CTL, 8'h30);
      wr(`SCWT_OFF_PIN_CTL, 8'h13);
      cycles(60);
      chk(clk_o, 1'b1);
      send_en = 1'b0;
      wr(`SCWT_OFF_PIN_CTL, 8'h20);
      cycles(50);
      chk({data_oe, data_o}, 2'b11);
      done("sync");
      // ETU divider; dividers rise so the counter never overshoots
      rate_code = 4'h6;
      period(232);
      rate_code = 4'hd;
      period(256);
      rate_code = 4'h2;
      adj_code = 4'h4;
      period(276);
      rate_code = 4'h0;
      adj_code = 4'h1;
      period(1488);
      done("divider");
      wrap_up();
   end
endmodule
